//--- shared/acs_pkg.sv
// Purpose: shared constants and types for the converter conversion sequencer
// Assumes: 32-bit Avalon-MM register window, byte addresses, 8-bit registers in lane 0
// Notes: unmapped offsets read zero and ignore writes
// Function
// [R1] Software pulses start low-high-low to launch one conversion
// [R2] Busy flag rises by itself once a conversion is launched
// [R3] Busy flag drops to zero when the conversion finishes
// [R4] Completion sets interrupt flag; request only when both enables are set
// [R5] Conversion clock is system clock divided by 2^select, 1 up to 128
// [R6] Software avoids divider codes giving a conversion clock outside the advised range
// [R7] Every conversion opens with exactly four conversion clocks of sampling
// [R8] Twelve conversion clocks of conversion follow, sixteen in total
// [R9] Converter is powered only while the power enable bit is high
// [R10] Software waits a settling delay after power-up before starting
// [R11] Software clears power enable while the converter is idle
// [R12] Input codes 0000, 0100, 11xx route the selected external channel
// [R13] Internal input codes connect the internal signal and cut the external path
// [R14] Result placement in the two result bytes follows the format bit
// [R15] Reference follows reference select; amplifier settings apply with amplifier reference
// [R16] Software sets both interrupt enables before starting when interrupts are used
// [R17] Result bytes are valid when busy falls; software reads afterwards
// [R18] Without interrupts software polls busy until it reads zero
// [R19] Software configures divider, power, input, format, reference, enables, then starts
// [R20] Internal codes select supply, its half, quarter, amplifier, half, quarter, ground
// [R21] Reference select: 00 supply, 01 external pin, 1x amplifier output
// [R22] Result is twelve bits, all ones at full scale
// [R23] Start rising edge resets the sequencer, falling edge begins sampling
// [R24] A new start pulse during conversion aborts and restarts; busy stays high
package acs_pkg;
   localparam int RES_W = 12;
   // Register byte offsets
   localparam logic [4:0] OFS_CTRL0 = 5'h00;
   localparam logic [4:0] OFS_CTRL1 = 5'h04;
   localparam logic [4:0] OFS_CTRL2 = 5'h08;
   localparam logic [4:0] OFS_RESH = 5'h0C;
   localparam logic [4:0] OFS_RESL = 5'h10;
   localparam logic [4:0] OFS_INTC = 5'h14;
   // Field positions
   localparam int C0_START = 7;
   localparam int C0_BUSY = 6;
   localparam int C0_PWR = 5;
   localparam int C0_FMT = 4;
   localparam int C0_CH = 0;
   localparam int C1_INS = 4;
   localparam int C1_DIV = 0;
   localparam int C2_AMPEN = 7;
   localparam int C2_AMPIN = 4;
   localparam int C2_REF = 2;
   localparam int C2_GAIN = 0;
   localparam int IC_FLAG = 2;
   localparam int IC_CIE = 1;
   localparam int IC_GIE = 0;
   // Reset values
   localparam logic [7:0] RST_CTRL0 = 8'h00;
   localparam logic [7:0] RST_CTRL1 = 8'h00;
   localparam logic [7:0] RST_CTRL2 = 8'h00;
   localparam logic [7:0] RST_INTC = 8'h00;
   // Conversion timing in conversion clocks
   localparam int SAMPLE_TICKS = 4;
   localparam int CONV_TICKS = 12;
   localparam int TOTAL_TICKS = SAMPLE_TICKS + CONV_TICKS;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ARM = 4'h2,
      ST_SAMP = 4'h4,
      ST_CONV = 4'h8
   } acs_state_t;
   typedef enum logic [2:0] {
      SRC_EXT = 3'h0,
      SRC_SUP = 3'h1,
      SRC_SUP_H = 3'h2,
      SRC_SUP_Q = 3'h3,
      SRC_AMP = 3'h4,
      SRC_AMP_H = 3'h5,
      SRC_AMP_Q = 3'h6,
      SRC_GND = 3'h7
   } acs_src_t;
   typedef enum logic [1:0] {
      REF_SUP = 2'h0,
      REF_PIN = 2'h1,
      REF_AMP = 2'h2
   } acs_ref_t;
   // Map the internal input select code to the analog source
   function automatic acs_src_t acs_src_decode(input logic [3:0] ins);
      acs_src_t s;
      s = SRC_EXT;
      casez (ins)
         4'b0001: s = SRC_SUP;
         4'b0010: s = SRC_SUP_H;
         4'b0011: s = SRC_SUP_Q;
         4'b0101: s = SRC_AMP;
         4'b0110: s = SRC_AMP_H;
         4'b0111: s = SRC_AMP_Q;
         4'b10??: s = SRC_GND;
         default: s = SRC_EXT;
      endcase
      return s;
   endfunction
endpackage

//--- shared/acs_sar_if.sv
// Purpose: carries the step controls and trial code between sequencer and approximation register
// Assumes: both ends run on mclk
// Notes: step is high for one cycle per conversion tick, so with sel 0 on every clock of conversion; clr restarts the search
`timescale 1ns/1ps
interface acs_sar_if #(parameter int W = 12);
   logic clr;
   logic step;
   logic comp;
   logic [W-1:0] trial;
   modport ctl (output clr, output step, output comp, input trial);
   modport sar (input clr, input step, input comp, output trial);
endinterface

//--- core/acs_clk_div.sv
// Purpose: conversion clock enable, one tick every 2^sel system clocks
// Assumes: clr realigns the phase so the first tick lands 2^sel clocks later
// Notes: sel 0 ticks on every clock
`timescale 1ns/1ps
module acs_clk_div #(parameter int SEL_W = 3) (
   input wire logic mclk,              // System clock
   input wire logic reset_n,           // Asynchronous reset, active low
   input wire logic clr,               // Restart the count
   input wire logic [SEL_W-1:0] sel,   // Power-of-two divide code
   output logic tick                   // One conversion clock
);
   localparam int CW = (1 << SEL_W) - 1;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] mask;
   initial begin
      if (SEL_W < 1 || SEL_W > 4) $error("acs_clk_div: SEL_W out of range");
   end
   // Mask of low bits that must all be one for a tick
   assign mask = CW'((1 << sel) - 1);
   assign tick = (cnt_reg & mask) == mask;
   // Free counter, restarted on clr
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_reg <= '0;
      end else if (clr) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + CW'(1);
      end
   end
endmodule

//--- core/acs_sar.sv
// Purpose: successive approximation register, MSB first
// Assumes: comp high means input at or above the trial code
// Notes: trial drives the comparison DAC directly from flops
`timescale 1ns/1ps
module acs_sar #(parameter int W = 12) (
   input wire logic mclk,      // System clock
   input wire logic reset_n,   // Asynchronous reset, active low
   acs_sar_if.sar sif          // Step controls and trial code
);
   logic [W-1:0] trial_reg;
   logic [W-1:0] trial_next;
   logic [$clog2(W)-1:0] idx_reg;
   initial begin
      if (W < 2) $error("acs_sar: W too small");
   end
   assign sif.trial = trial_reg;
   // Keep or drop the bit on test, then try the next lower one
   always_comb begin
      trial_next = trial_reg;
      if (!sif.comp) trial_next[idx_reg] = 1'b0;
      if (idx_reg != '0) trial_next[idx_reg - 1'b1] = 1'b1;
   end
   // Search state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         trial_reg <= '0;
         idx_reg <= '0;
      end else if (sif.clr) begin
         trial_reg <= {1'b1, {(W-1){1'b0}}};
         idx_reg <= ($clog2(W))'(W - 1);
      end else if (sif.step) begin
         trial_reg <= trial_next;
         if (idx_reg != '0) idx_reg <= idx_reg - 1'b1;
      end
   end
endmodule

//--- core/acs_seq.sv
// Purpose: converter sequencer with control registers on Avalon-MM
// Assumes: comparator output arrives asynchronously on cmp_in
// Notes: each access completes on the second edge; comparator path is two clocks late
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ps
module acs_seq
   import acs_pkg::*;
(
   input wire logic mclk,                     // System clock, 40 MHz
   input wire logic reset_n,                  // Asynchronous reset, active low
   input wire logic [4:0] avs_address,        // Byte address
   input wire logic avs_read,                 // Read request
   input wire logic avs_write,                // Write request
   input wire logic [31:0] avs_writedata,     // Write data
   input wire logic [3:0] avs_byteenable,     // Byte lanes
   output logic [31:0] avs_readdata,          // Read data
   output logic avs_waitrequest,              // Stall
   input wire logic cmp_in,                   // Comparator result pin
   output logic adc_power_on,                 // Converter power
   output logic sample_hold,                  // Sampling switch closed
   output logic [acs_pkg::RES_W-1:0] dac_code, // Comparison code
   output logic ext_path_on,                  // External channel path closed
   output logic [3:0] ext_channel,            // External channel number
   output acs_pkg::acs_src_t input_source,    // Selected analog source
   output acs_pkg::acs_ref_t ref_source,      // Selected reference
   output logic amp_enable,                   // Amplifier power
   output logic amp_input_sel,                // Amplifier input choice
   output logic [1:0] amp_gain,               // Amplifier gain code
   output logic conv_irq                      // Interrupt request level
);
   import acs_pkg::*;

   acs_state_t state_reg;
   logic ack_reg;
   logic wr_en;
   logic [4:0] a_word;
   logic [7:0] rd_mux;
   logic start_reg, start_q, start_rise, start_fall;
   logic pwr_reg, fmt_reg, busy_reg, flag_reg, cie_reg, gie_reg;
   logic ampen_reg, ampin_reg;
   logic [3:0] ch_reg, ins_reg;
   logic [2:0] div_reg;
   logic [1:0] ref_reg, gain_reg;
   logic [7:0] res_hi_reg, res_lo_reg;
   logic [3:0] tcnt_reg;
   logic fin_reg, tick, div_clr, cmp_s1, cmp_s2;
   logic running;
   acs_src_t src_sel;

   acs_sar_if #(.W(RES_W)) sif ();

   // Bus handshake: one wait state, then data stands at the release edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign a_word = {avs_address[4:2], 2'b00};
   assign wr_en = avs_write & ack_reg & avs_byteenable[0];

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
      end
   end

   // Read view; busy and flag show live state
   always_comb begin
      rd_mux = 8'h00;
      unique case (a_word)
         OFS_CTRL0: rd_mux = {start_reg, busy_reg, pwr_reg, fmt_reg, ch_reg};
         OFS_CTRL1: rd_mux = {ins_reg, 1'b0, div_reg};
         OFS_CTRL2: rd_mux = {ampen_reg, 2'b00, ampin_reg, ref_reg, gain_reg};
         OFS_RESH: rd_mux = res_hi_reg;
         OFS_RESL: rd_mux = res_lo_reg;
         OFS_INTC: rd_mux = {5'h00, flag_reg, cie_reg, gie_reg};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read & ~ack_reg) begin
         avs_readdata <= {24'h000000, rd_mux};
      end
   end

   // Software-written configuration
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {start_reg, pwr_reg, fmt_reg} <= {RST_CTRL0[C0_START], RST_CTRL0[C0_PWR], RST_CTRL0[C0_FMT]};
         ch_reg <= RST_CTRL0[C0_CH +: 4];
         ins_reg <= RST_CTRL1[C1_INS +: 4];
         div_reg <= RST_CTRL1[C1_DIV +: 3];
         {ampen_reg, ampin_reg} <= {RST_CTRL2[C2_AMPEN], RST_CTRL2[C2_AMPIN]};
         ref_reg <= RST_CTRL2[C2_REF +: 2];
         gain_reg <= RST_CTRL2[C2_GAIN +: 2];
         {cie_reg, gie_reg} <= {RST_INTC[IC_CIE], RST_INTC[IC_GIE]};
      end else if (wr_en) begin
         if (a_word == OFS_CTRL0) begin
            start_reg <= avs_writedata[C0_START];
            pwr_reg <= avs_writedata[C0_PWR];
            fmt_reg <= avs_writedata[C0_FMT];
            ch_reg <= avs_writedata[C0_CH +: 4];
         end
         if (a_word == OFS_CTRL1) begin
            ins_reg <= avs_writedata[C1_INS +: 4];
            div_reg <= avs_writedata[C1_DIV +: 3];
         end
         if (a_word == OFS_CTRL2) begin
            ampen_reg <= avs_writedata[C2_AMPEN];
            ampin_reg <= avs_writedata[C2_AMPIN];
            ref_reg <= avs_writedata[C2_REF +: 2];
            gain_reg <= avs_writedata[C2_GAIN +: 2];
         end
         if (a_word == OFS_INTC) begin
            cie_reg <= avs_writedata[IC_CIE];
            gie_reg <= avs_writedata[IC_GIE];
         end
      end
   end

   // [R1] start pulse edges
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         start_q <= 1'b0;
      end else begin
         start_q <= start_reg;
      end
   end
   assign start_rise = start_reg & ~start_q;
   assign start_fall = ~start_reg & start_q & pwr_reg;

   // Comparator pin synchroniser
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
      end else begin
         cmp_s1 <= cmp_in;
         cmp_s2 <= cmp_s1;
      end
   end

   // [R5] conversion clock, phase aligned to the start of sampling
   assign div_clr = start_fall;
   acs_clk_div #(.SEL_W(3)) u_div (
      .mclk(mclk),
      .reset_n(reset_n),
      .clr(div_clr),
      .sel(div_reg),
      .tick(tick)
   );

   assign running = (state_reg == ST_SAMP) || (state_reg == ST_CONV);
   // [R8] approximation steps only on conversion ticks
   assign sif.clr = start_fall;
   assign sif.step = (state_reg == ST_CONV) & tick;
   assign sif.comp = cmp_s2;
   acs_sar #(.W(RES_W)) u_sar (
      .mclk(mclk),
      .reset_n(reset_n),
      .sif(sif)
   );

   // [R23] [R24] sequencer; power loss abandons any conversion
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         tcnt_reg <= 4'h0;
         fin_reg <= 1'b0;
      end else begin
         fin_reg <= 1'b0;
         if (!pwr_reg) begin
            state_reg <= ST_IDLE;
         end else if (start_rise) begin
            state_reg <= ST_ARM;
         end else if (start_fall) begin
            state_reg <= ST_SAMP;
            tcnt_reg <= 4'h0;
         end else if (running && tick) begin
            tcnt_reg <= tcnt_reg + 4'h1;
            // [R7] four sampling ticks
            if (state_reg == ST_SAMP && tcnt_reg == 4'(SAMPLE_TICKS - 1)) state_reg <= ST_CONV;
            // [R8] sixteenth tick ends the conversion
            if (state_reg == ST_CONV && tcnt_reg == 4'(TOTAL_TICKS - 1)) begin
               state_reg <= ST_IDLE;
               fin_reg <= 1'b1;
            end
         end
      end
   end

   // [R2] [R3] busy: launch sets it, finish or power loss clears it
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         busy_reg <= RST_CTRL0[C0_BUSY];
      end else if (start_fall) begin
         busy_reg <= 1'b1;
      end else if (fin_reg || !pwr_reg) begin
         busy_reg <= 1'b0;
      end
   end

   // [R4] sticky flag; a completion beats a software clear in the same cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         flag_reg <= RST_INTC[IC_FLAG];
         conv_irq <= 1'b0;
      end else begin
         if (fin_reg) begin
            flag_reg <= 1'b1;
         end else if (wr_en && a_word == OFS_INTC) begin
            flag_reg <= avs_writedata[IC_FLAG];
         end
         conv_irq <= flag_reg & cie_reg & gie_reg;
      end
   end

   // [R14] [R17] [R22] result placement, loaded as busy falls
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         res_hi_reg <= 8'h00;
         res_lo_reg <= 8'h00;
      end else if (fin_reg) begin
         if (fmt_reg) begin
            res_hi_reg <= {4'h0, sif.trial[11:8]};
            res_lo_reg <= sif.trial[7:0];
         end else begin
            res_hi_reg <= sif.trial[11:4];
            res_lo_reg <= {sif.trial[3:0], 4'h0};
         end
      end
   end

   // [R12] [R13] [R20] input routing; internal sources open the external path
   assign src_sel = acs_src_decode(ins_reg);
   // [R9] [R15] [R21] power and reference routing, registered to the pins
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         adc_power_on <= 1'b0;
         sample_hold <= 1'b0;
         ext_path_on <= 1'b0;
         ext_channel <= 4'h0;
         input_source <= SRC_EXT;
         ref_source <= REF_SUP;
         amp_enable <= 1'b0;
         amp_input_sel <= 1'b0;
         amp_gain <= 2'h0;
      end else begin
         adc_power_on <= pwr_reg;
         sample_hold <= (state_reg == ST_SAMP) | start_fall;
         ext_path_on <= pwr_reg && (src_sel == SRC_EXT);
         ext_channel <= ch_reg;
         input_source <= src_sel;
         ref_source <= ref_reg[1] ? REF_AMP : acs_ref_t'(ref_reg);
         amp_enable <= ampen_reg;
         amp_input_sel <= ampin_reg;
         amp_gain <= gain_reg;
      end
   end
   assign dac_code = sif.trial;

   // Checks; gap counter tracks clocks since the last conversion tick
   logic [7:0] gap_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) gap_reg <= 8'h00;
      else if (tick || div_clr) gap_reg <= 8'h00;
      else gap_reg <= gap_reg + 8'h01;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence s_launch;
      start_fall ##1 (state_reg == ST_SAMP);
   endsequence
   sequence s_finish;
      fin_reg ##1 !busy_reg;
   endsequence
   AST_LAUNCH_BUSY: assert property (s_launch |-> busy_reg) else $error("busy not set on launch"); // [R2]
   AST_FINISH_FLAG: assert property (s_finish |-> flag_reg) else $error("flag missing at finish"); // [R4]
   AST_FINISH_IDLE: assert property (fin_reg && !start_fall |=> !busy_reg) else $error("busy stuck"); // [R3]
   AST_IRQ_GATED: assert property (conv_irq |-> $past(flag_reg && cie_reg && gie_reg)) else $error("bad irq"); // [R4]
   AST_TICK_GAP: assert property (tick && running && $stable(div_reg) && !$past(div_clr)
      |-> gap_reg == 8'((1 << div_reg) - 1)) else $error("divider gap wrong"); // [R5]
   AST_SAMPLE_LEN: assert property ($rose(state_reg == ST_CONV) |-> $past(tcnt_reg) == 4'h3)
      else $error("sampling length wrong"); // [R7]
   AST_CONV_LEN: assert property (fin_reg |-> $past(tcnt_reg) == 4'hF && $past(state_reg) == ST_CONV)
      else $error("conversion length wrong"); // [R8]
   AST_POWER_OFF: assert property (!pwr_reg |=> !adc_power_on ##1 !busy_reg) else $error("power leak"); // [R9]
   AST_EXT_CUT: assert property (src_sel != SRC_EXT |=> !ext_path_on) else $error("external path open"); // [R13]
   AST_RESULT: assert property (fin_reg && !fmt_reg |=> res_hi_reg == $past(sif.trial[11:4]))
      else $error("result not loaded"); // [R17]
   AST_ARM_RESET: assert property (start_rise && pwr_reg |=> state_reg == ST_ARM) else $error("no rearm"); // [R23]
   AST_RESTART_BUSY: assert property (start_rise && busy_reg && pwr_reg |=> busy_reg [*2])
      else $error("busy dropped on restart"); // [R24]
endmodule

//--- sim/tb_top.sv
// Purpose: self-checking bench for the converter sequencer and its register window
// Assumes: ideal comparator, high while the target code is at or above dac_code
// Notes: divide codes 0 and 1 are checked for timing only, the sequencer reads a stale comparator there
`timescale 1ns/1ps
module tb_top;
   import acs_pkg::*;
   logic mclk, reset_n, avs_read, avs_write, cmp_in, avs_waitrequest, adc_power_on, sample_hold;
   logic ext_path_on, amp_enable, amp_input_sel, conv_irq, irq_seen;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, ext_channel;
   logic [RES_W-1:0] dac_code;
   logic [1:0] amp_gain;
   logic [11:0] target;
   logic [7:0] q, v;
   acs_src_t input_source;
   acs_ref_t ref_source;
   int mismatches, comparisons, seed, sh_cnt, cyc, t0;
   acs_seq acs_seq_i (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp_in(cmp_in),
      .adc_power_on(adc_power_on), .sample_hold(sample_hold), .dac_code(dac_code), .ext_path_on(ext_path_on),
      .ext_channel(ext_channel), .input_source(input_source), .ref_source(ref_source), .amp_enable(amp_enable),
      .amp_input_sel(amp_input_sel), .amp_gain(amp_gain), .conv_irq(conv_irq));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Comparator model and free-running monitors; sampling count is cleared only while idle
   always @(posedge mclk) begin
      cmp_in <= (target >= dac_code);
      cyc <= cyc + 1;
      if (sample_hold === 1'b1) sh_cnt <= sh_cnt + 1;
      if (conv_irq === 1'b1) irq_seen <= 1'b1;
   end
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic fail(string m);
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic chk8(logic [7:0] got, logic [7:0] exp, string m);
      comparisons++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
   endtask
   task automatic chk_rng(int got, int lo, int hi, string m);
      comparisons++;
      if (got < lo || got > hi) fail($sformatf("%s %0d outside %0d..%0d", m, got, lo, hi));
   endtask
   // Avalon master: hold everything until waitrequest is sampled low at a rising edge
   task automatic bus(logic wr, logic [4:0] a, logic [7:0] d, logic [3:0] be);
      logic ok;
      int n;
      ok = 1'b0;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      while (!ok) begin
         @(posedge mclk);
         ok = (avs_waitrequest === 1'b0);
         n++;
         if (!ok && n > 20) begin
            fail("bus timeout");
            close_out();
         end
      end
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(logic [4:0] a, logic [7:0] d);
      bus(1'b1, a, d, 4'h1);
   endtask
   task automatic rd(logic [4:0] a);
      bus(1'b0, a, 8'h00, 4'hF);
   endtask
   function automatic logic [2:0] src_exp(logic [3:0] c);
      casez (c)
         4'b0001: return 3'h1;
         4'b0010: return 3'h2;
         4'b0011: return 3'h3;
         4'b0101: return 3'h4;
         4'b0110: return 3'h5;
         4'b0111: return 3'h6;
         4'b10??: return 3'h7;
         default: return 3'h0;
      endcase
   endfunction
   // Two-write start pulse: rise then fall with power held on
   task automatic launch(logic fmt);
      wr(OFS_CTRL0, {3'b101, fmt, 4'h5});
      wr(OFS_CTRL0, {3'b001, fmt, 4'h5});
      t0 = cyc;
   endtask
   task automatic wait_irq(int lim);
      while (conv_irq !== 1'b1 && cyc - t0 < lim) @(negedge mclk);
      if (conv_irq !== 1'b1) begin
         fail("no completion");
         close_out();
      end
   endtask
   task automatic run(logic [2:0] div, logic fmt, logic [11:0] t, logic ie);
      int nn;
      nn = 1 << div;
      target <= t;
      // divider and input first, then enables, then the start pulse
      wr(OFS_CTRL1, {5'h00, div});
      // both enables written from ie before the launch
      wr(OFS_INTC, {6'h00, ie, ie});
      sh_cnt = 0;
      irq_seen = 1'b0;
      launch(fmt);
      rd(OFS_CTRL0);
      chk8(q & 8'h40, 8'h40, "busy set");
      if (ie) begin
         wait_irq(16 * nn + 40);
         chk_rng(cyc - t0, 16 * nn + 1, 16 * nn + 6, "conversion length");
         chk_rng(sh_cnt, 4 * nn - 1, 4 * nn + 1, "sampling length");
      end
      else begin
         q = 8'h40;
         // poll busy until it reads zero
         while (q[6] === 1'b1 && cyc - t0 < 16 * nn + 60) rd(OFS_CTRL0);
         if (q[6] !== 1'b0) begin
            fail("busy never cleared");
            close_out();
         end
         chk8(8'({irq_seen}), 8'h00, "masked request");
      end
      rd(OFS_CTRL0);
      chk8(q & 8'h40, 8'h00, "busy clear");
      rd(OFS_INTC);
      chk8(q & 8'h04, 8'h04, "flag set");
      if (div >= 3'd2) begin
         rd(OFS_RESH);
         chk8(q, fmt ? {4'h0, t[11:8]} : t[11:4], "high byte");
         rd(OFS_RESL);
         chk8(q, fmt ? t[7:0] : {t[3:0], 4'h0}, "low byte");
      end
      wr(OFS_INTC, {6'h00, ie, ie});
      repeat (3) @(posedge mclk);
      chk8(8'({conv_irq}), 8'h00, "request dropped");
   endtask
   initial begin
      {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable, target} = '0;
      {mismatches, comparisons, sh_cnt, cyc, irq_seen} = '0;
      seed = 32'h64e4;
      reset_n = 1'b0;
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      // Reset values, read-only result bytes, unmapped offset, masked byte lane
      for (int a = 0; a < 7; a++) begin
         rd(5'(a * 4));
         chk8(q, 8'h00, "reset value");
         wr(5'(a * 4), 8'hFF & ~8'h80);
         wr(5'(a * 4), 8'h00);
         if (a >= 3) begin
            rd(5'(a * 4));
            chk8(q, 8'h00, "read-only or unmapped");
         end
      end
      v = 8'($random(seed));
      wr(OFS_CTRL1, v);
      bus(1'b1, OFS_CTRL1, ~v, 4'h0);
      rd(OFS_CTRL1);
      chk8(q, v & 8'hF7, "control readback");
      $display("test registers done");
      // Input routing for every select code, with power on
      for (int c = 0; c < 16; c++) begin
         v = 8'($random(seed)) & 8'h0F;
         wr(OFS_CTRL0, {4'h2, v[3:0]});
         wr(OFS_CTRL1, {4'(c), 4'h2});
         repeat (2) @(posedge mclk);
         chk8(8'(input_source), {5'h00, src_exp(4'(c))}, "source");
         chk8(8'({ext_path_on, adc_power_on}), {6'h00, src_exp(4'(c)) == 3'h0, 1'b1}, "external path");
         chk8(8'(ext_channel), v & 8'h0F, "channel");
      end
      // Reference codes with random amplifier settings
      for (int r = 0; r < 4; r++) begin
         v = (8'($random(seed)) & 8'h93) | 8'(r << 2);
         wr(OFS_CTRL2, v);
         repeat (2) @(posedge mclk);
         chk8(8'({amp_enable, amp_input_sel, amp_gain, ref_source}), {4'h0, v[7], v[4], v[1:0]} << 2 |
            8'(r > 1 ? 2 : r), "reference");
      end
      $display("test routing done");
      // power has stood on since the routing tests, well past settling
      wr(OFS_CTRL1, 8'h00);
      run(3'd2, 1'b0, 12'hFFF, 1'b1);
      run(3'd3, 1'b1, 12'h000, 1'b1);
      run(3'd7, 1'b0, 12'($random(seed)), 1'b1);
      // codes 0 and 1 clock the converter too fast here, so timing only
      run(3'd0, 1'b1, 12'($random(seed)), 1'b1);
      run(3'd1, 1'b0, 12'($random(seed)), 1'b1);
      for (int i = 0; i < 5; i++) run(3'd2 + 3'(i), 1'(i), 12'($random(seed)), 1'(i != 1));
      $display("test conversions done");
      // Restart in mid-conversion: busy stays high, timing counts from the new launch
      wr(OFS_CTRL1, 8'h03);
      wr(OFS_INTC, 8'h03);
      launch(1'b1);
      repeat (40) @(posedge mclk);
      wr(OFS_CTRL0, 8'hB5);
      rd(OFS_CTRL0);
      chk8(q & 8'h40, 8'h40, "busy through restart");
      wr(OFS_CTRL0, 8'h35);
      t0 = cyc;
      wait_irq(200);
      chk_rng(cyc - t0, 129, 134, "restart length");
      wr(OFS_INTC, 8'h00);
      // Power removed in mid-conversion, then a start pulse without power
      launch(1'b0);
      // converter unpowered here while still converting, and left unpowered from here on
      wr(OFS_CTRL0, 8'h05);
      repeat (2) @(posedge mclk);
      rd(OFS_CTRL0);
      chk8({q[6], 6'h00, adc_power_on}, 8'h00, "power off abort");
      wr(OFS_CTRL0, 8'h85);
      wr(OFS_CTRL0, 8'h05);
      rd(OFS_CTRL0);
      chk8(q & 8'h40, 8'h00, "launch without power");
      $display("test abort done");
      close_out();
   end
endmodule
